// File: rtic_pkg.sv
// Purpose: Shared constants for the ratio/interval/totalize counter
// Assumes: 125 MHz system clock, AXI4-Lite register access
// Notes:   Times are kept in their own unit; cycle counts derive from them
package rtic_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CLK_KHZ       = 125000;
  localparam int unsigned MIN_RES_NS    = 100;
  localparam int unsigned MIN_RES_CYC   = (MIN_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GATE_A_MS     = 200;
  localparam int unsigned GATE_B_MS     = 1000;
  localparam int unsigned GATE_C_MS     = 10000;
  localparam int unsigned HOLD_MS       = 1000;
  localparam logic [31:0] GATE_A_CYC    = 32'(64'(GATE_A_MS) * 64'(CLK_KHZ));
  localparam logic [31:0] GATE_B_CYC    = 32'(64'(GATE_B_MS) * 64'(CLK_KHZ));
  localparam logic [31:0] GATE_C_CYC    = 32'(64'(GATE_C_MS) * 64'(CLK_KHZ));
  localparam logic [31:0] HOLD_CYC      = 32'(64'(HOLD_MS) * 64'(CLK_KHZ) + 64'd1);
  localparam logic [3:0]  PRESCALE_LAST = 4'h9;
  localparam logic [63:0] KILO_PULSES   = 64'h0000_0000_0000_03E8;
  localparam logic [63:0] MEGA_PULSES   = 64'h0000_0000_000F_4240;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_RESULT_LO = 8'h08;
  localparam logic [7:0] OFS_RESULT_HI = 8'h0C;
  localparam logic [7:0] OFS_TOTAL_LO  = 8'h10;
  localparam logic [7:0] OFS_TOTAL_HI  = 8'h14;

  // Control fields
  localparam int CTRL_FUNC_LSB = 0;
  localparam int CTRL_START    = 3;
  localparam int CTRL_SLOPE_A  = 4;
  localparam int CTRL_SLOPE_B  = 5;
  localparam int CTRL_GATE_LSB = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status fields
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
  localparam int STAT_UNDER = 2;
  localparam int STAT_GATE  = 3;
  localparam int STAT_KILO  = 4;
  localparam int STAT_MEGA  = 5;
  localparam int STAT_HF    = 6;
  localparam int STAT_MRUN  = 7;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------
  // Functions and states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_PERIOD   = 3'b000,
    FN_RATIO    = 3'b001,
    FN_INTERVAL = 3'b010,
    FN_GATED    = 3'b011,
    FN_EDGE     = 3'b100,
    FN_MANUAL   = 3'b101,
    FN_HF_FREQ  = 3'b110,
    FN_SPARE    = 3'b111
  } rtic_func_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM  = 2'b01,
    ST_RUN  = 2'b10,
    ST_DIV  = 2'b11
  } rtic_state_t;

endpackage

// File: rtic_divider.sv
// Purpose: Iterative unsigned divider, one quotient bit per clock
// Assumes: Operands stay stable only at the start pulse
// Notes:   Division by zero yields an all-ones quotient
module rtic_divider #(
  parameter int W = 64
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  // Request
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  // Answer
  output logic              done,
  output logic [W-1:0]      quo_ff
);

  logic [W-1:0] den_ff;
  logic [W:0]   rem_ff;
  logic [7:0]   bit_ff;
  logic         run_ff;
  logic [W:0]   trial;

  // Shifted remainder to test against the divisor
  always_comb begin
    trial = {rem_ff[W-1:0], quo_ff[W-1]};
  end

  // Restoring division: slow but tiny, the measurement is far slower
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      den_ff <= '0;
      rem_ff <= '0;
      quo_ff <= '0;
      bit_ff <= 8'h00;
      run_ff <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        den_ff <= den;
        rem_ff <= '0;
        quo_ff <= num;
        bit_ff <= 8'(W);
        run_ff <= 1'b1;
      end else if (run_ff) begin
        if (trial >= {1'b0, den_ff}) begin
          rem_ff <= trial - {1'b0, den_ff};
          quo_ff <= {quo_ff[W-2:0], 1'b1};
        end else begin
          rem_ff <= trial;
          quo_ff <= {quo_ff[W-2:0], 1'b0};
        end
        bit_ff <= bit_ff - 8'h01;
        if (bit_ff == 8'h01) begin
          run_ff <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end

endmodule

// File: rtic_press_timer.sv
// Purpose: Start/stop button press and long-hold detection
// Assumes: Button level is clean and synchronous to the clock
// Notes:   Hold pulse fires once per press, after HOLD_CYC cycles held
module rtic_press_timer #(
  parameter logic [31:0] HOLD_CYC = 32'd125000001
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Button
  input  wire logic btn,
  // Events
  output logic      press_pulse,
  output logic      hold_pulse
);

  logic        btn_q_ff;
  logic [31:0] held_ff;

  // Edge and hold counter; counter saturates so the hold fires once
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      btn_q_ff    <= 1'b0;
      held_ff     <= 32'h0000_0000;
      press_pulse <= 1'b0;
      hold_pulse  <= 1'b0;
    end else begin
      btn_q_ff    <= btn;
      press_pulse <= btn & ~btn_q_ff;
      hold_pulse  <= 1'b0;
      if (!btn) begin
        held_ff <= 32'h0000_0000;
      end else if (held_ff < HOLD_CYC) begin
        held_ff <= held_ff + 32'h0000_0001;
        if (held_ff == HOLD_CYC - 32'h0000_0001) begin
          hold_pulse <= 1'b1;
        end
      end
    end
  end

endmodule

// File: rtic_core.sv
// Purpose: Period, ratio, interval and totalize measurement with AXI4-Lite registers
// Assumes: Inputs A, B and the button are synchronous to clk_sys
// Notes:   Times are reported in clk_sys cycles of 8 ns; totals in pulses
//
// Operation
// - Single period times exactly one input cycle
// - Gated period prescales by ten, reports mean
// - Ratio divides A count by B count
// - Interval times A rising to B rising
// - Averaged interval reports zero up to twenty s
// - Slope selects per channel for interval
// - Gated totalize counts A during B pulse
// - Inverted B slope counts during low pulse
// - Edge totalize counts between two B edges
// - Button press alternately starts and stops counting
// - Holding button over one second clears total
// - Totals flagged kilo or mega for display
// - Gate indicator off in manual totalize
// - Function select skips absent HF channel
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
module rtic_core
  import rtic_pkg::*;
#(
  parameter int          CNT_W    = 64,
  parameter logic [31:0] GATE_A   = GATE_A_CYC,
  parameter logic [31:0] GATE_B   = GATE_B_CYC,
  parameter logic [31:0] GATE_C   = GATE_C_CYC,
  parameter logic [31:0] HOLD_LEN = HOLD_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Conditioned inputs and front panel
  input  wire logic        in_a,
  input  wire logic        in_b,
  input  wire logic        btn_start_stop,
  input  wire logic        hf_present,
  // Indicators
  output logic             gate_ind,
  output logic             disp_kilo,
  output logic             disp_mega
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  rtic_func_t       func_ff;
  rtic_state_t      state_ff;
  logic             slope_a_ff, slope_b_ff, start_ff;
  logic [1:0]       gate_sel_ff;
  logic             done_ff, under_ff, in_iv_ff, man_run_ff;
  logic             a_q_ff, b_q_ff;
  logic             a_ev, b_start, b_stop, avg, gate_exp;
  logic [3:0]       pre_ff;
  logic [31:0]      gate_cnt_ff, gate_lim;
  logic [CNT_W-1:0] cyc_ff, a_cnt_ff, b_cnt_ff, man_tot_ff, result_ff, total;
  logic             div_go_ff, div_done;
  logic [CNT_W-1:0] div_num_ff, div_den_ff, div_quo;
  logic             press, hold;
  logic [7:0]       aw_addr_ff;
  logic             aw_got_ff, w_got_ff;
  logic [31:0]      w_data_ff;
  logic [3:0]       w_strb_ff;
  logic             wr_fire, clr_done, tot_fn;
  logic [7:0]       status;
  logic [2:0]       new_func;

  // Selected edge of a channel: rising, or falling when inverted
  function automatic logic sel_edge(input logic prev, input logic cur, input logic fall);
    sel_edge = fall ? (prev & ~cur) : (~prev & cur);
  endfunction

  // Range check of a register offset
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_RESULT_LO) ||
             (a == OFS_RESULT_HI) || (a == OFS_TOTAL_LO) || (a == OFS_TOTAL_HI);
  endfunction

  // ---------------------------------------------------------------
  // Input edge events
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      a_q_ff <= 1'b0;
      b_q_ff <= 1'b0;
    end else begin
      a_q_ff <= in_a;
      b_q_ff <= in_b;
    end
  end

  // Slope inversion per channel; B stop is the opposite B edge when gated
  assign a_ev    = sel_edge(a_q_ff, in_a, slope_a_ff);
  assign b_start = sel_edge(b_q_ff, in_b, slope_b_ff);
  assign b_stop  = (func_ff == FN_GATED) ? sel_edge(b_q_ff, in_b, ~slope_b_ff)
                                         : b_start;
  assign avg     = (gate_sel_ff != 2'b00);

  // Gate length from the measuring-time selection
  always_comb begin
    unique case (gate_sel_ff)
      2'b01:   gate_lim = GATE_A;
      2'b10:   gate_lim = GATE_B;
      2'b11:   gate_lim = GATE_C;
      default: gate_lim = 32'h0000_0000;
    endcase
  end
  assign gate_exp = (gate_cnt_ff >= gate_lim);

  // ---------------------------------------------------------------
  // Measurement sequencer
  // ---------------------------------------------------------------
  // Counters widened to CNT_W so totals to ten to the fifteenth never wrap
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= ST_IDLE;
      cyc_ff      <= '0;
      a_cnt_ff    <= '0;
      b_cnt_ff    <= '0;
      gate_cnt_ff <= 32'h0000_0000;
      pre_ff      <= 4'h0;
      in_iv_ff    <= 1'b0;
      result_ff   <= '0;
      under_ff    <= 1'b0;
      div_go_ff   <= 1'b0;
      div_num_ff  <= '0;
      div_den_ff  <= '0;
      done_ff     <= 1'b0;
    end else begin
      div_go_ff <= 1'b0;
      if (clr_done) begin
        done_ff <= 1'b0;
      end
      unique case (state_ff)
        ST_IDLE: begin
          if (start_ff && func_ff != FN_MANUAL && func_ff != FN_HF_FREQ &&
              func_ff != FN_SPARE) begin
            state_ff    <= (func_ff == FN_RATIO) ? ST_RUN : ST_ARM;
            cyc_ff      <= '0;
            a_cnt_ff    <= '0;
            b_cnt_ff    <= '0;
            gate_cnt_ff <= 32'h0000_0000;
            pre_ff      <= 4'h0;
            in_iv_ff    <= 1'b0;
            under_ff    <= 1'b0;
          end
        end
        ST_ARM: begin
          // Wait for the opening edge of the measurement; averaged interval moves on at once
          if ((func_ff == FN_PERIOD && a_ev) ||
              (func_ff == FN_INTERVAL && !avg && a_ev) ||
              (func_ff == FN_INTERVAL && avg) ||
              ((func_ff == FN_GATED || func_ff == FN_EDGE) && b_start)) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          gate_cnt_ff <= gate_cnt_ff + 32'h0000_0001;
          unique case (func_ff)
            FN_PERIOD: begin
              cyc_ff <= cyc_ff + 1'b1;
              if (a_ev && !avg) begin
                result_ff <= cyc_ff + 1'b1;
                under_ff  <= (cyc_ff + 1'b1) < CNT_W'(MIN_RES_CYC);
                done_ff   <= 1'b1;
                state_ff  <= ST_IDLE;
              end else if (a_ev) begin
                a_cnt_ff <= a_cnt_ff + 1'b1;
                pre_ff   <= (pre_ff == PRESCALE_LAST) ? 4'h0 : pre_ff + 4'h1;
                // Close only on a whole prescaled period past the gate
                if (pre_ff == PRESCALE_LAST && gate_exp) begin
                  div_num_ff <= cyc_ff + 1'b1;
                  div_den_ff <= a_cnt_ff + 1'b1;
                  div_go_ff  <= 1'b1;
                  state_ff   <= ST_DIV;
                end
              end
            end
            FN_RATIO: begin
              if (gate_exp) begin
                div_num_ff <= a_cnt_ff;
                div_den_ff <= b_cnt_ff;
                div_go_ff  <= 1'b1;
                state_ff   <= ST_DIV;
              end else begin
                a_cnt_ff <= a_cnt_ff + (a_ev ? 1'b1 : 1'b0);
                b_cnt_ff <= b_cnt_ff + (b_start ? 1'b1 : 1'b0);
              end
            end
            FN_INTERVAL: begin
              if (!avg) begin
                cyc_ff <= cyc_ff + 1'b1;
                if (b_start) begin
                  result_ff <= cyc_ff + 1'b1;
                  under_ff  <= (cyc_ff + 1'b1) < CNT_W'(MIN_RES_CYC);
                  done_ff   <= 1'b1;
                  state_ff  <= ST_IDLE;
                end
              end else if (in_iv_ff) begin
                cyc_ff <= cyc_ff + 1'b1;
                if (b_start) begin
                  in_iv_ff <= 1'b0;
                  b_cnt_ff <= b_cnt_ff + 1'b1;
                end
              end else if (gate_exp) begin
                // Mean of many intervals; quotient in whole cycles, remainder dropped
                div_num_ff <= cyc_ff;
                div_den_ff <= b_cnt_ff;
                div_go_ff  <= 1'b1;
                state_ff   <= ST_DIV;
              end else if (a_ev && b_start) begin
                b_cnt_ff <= b_cnt_ff + 1'b1;
              end else if (a_ev) begin
                in_iv_ff <= 1'b1;
              end
            end
            FN_GATED, FN_EDGE: begin
              if (b_stop) begin
                result_ff <= a_cnt_ff + (a_ev ? 1'b1 : 1'b0);
                done_ff   <= 1'b1;
                state_ff  <= ST_IDLE;
              end
              a_cnt_ff <= a_cnt_ff + (a_ev ? 1'b1 : 1'b0);
            end
            default: state_ff <= ST_IDLE;
          endcase
        end
        ST_DIV: begin
          if (div_done) begin
            result_ff <= div_quo;
            done_ff   <= 1'b1;
            state_ff  <= ST_IDLE;
          end
        end
      endcase
    end
  end

  rtic_divider #(
    .W       (CNT_W)
  ) u_div (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .start   (div_go_ff),
    .num     (div_num_ff),
    .den     (div_den_ff),
    .done    (div_done),
    .quo_ff  (div_quo)
  );

  // ---------------------------------------------------------------
  // Manual totalize
  // ---------------------------------------------------------------
  rtic_press_timer #(
    .HOLD_CYC    (HOLD_LEN)
  ) u_btn (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .btn         (btn_start_stop),
    .press_pulse (press),
    .hold_pulse  (hold)
  );

  // Press toggles run; long hold clears, and an A pulse then is dropped
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      man_run_ff <= 1'b0;
      man_tot_ff <= '0;
    end else if (func_ff != FN_MANUAL) begin
      man_run_ff <= 1'b0;
    end else begin
      if (press) begin
        man_run_ff <= ~man_run_ff;
      end
      if (hold) begin
        man_tot_ff <= '0;
      end else if (man_run_ff && a_ev) begin
        man_tot_ff <= man_tot_ff + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Indicators
  // ---------------------------------------------------------------
  assign total = (func_ff == FN_MANUAL) ? man_tot_ff :
                 (state_ff == ST_RUN) ? a_cnt_ff : result_ff;
  // Prefixes only mean pulses in the three totalize functions
  assign tot_fn = (func_ff inside {FN_GATED, FN_EDGE, FN_MANUAL});

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gate_ind  <= 1'b0;
      disp_kilo <= 1'b0;
      disp_mega <= 1'b0;
    end else begin
      gate_ind  <= (state_ff == ST_RUN) && (func_ff != FN_MANUAL);
      disp_mega <= tot_fn && (total >= MEGA_PULSES);
      disp_kilo <= tot_fn && (total >= KILO_PULSES) &&
                   (total < MEGA_PULSES);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign s_axi_awready = ~aw_got_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire       = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  assign clr_done      = wr_fire && aw_addr_ff == OFS_STATUS && w_strb_ff[0] &&
                         w_data_ff[STAT_DONE];
  // Cursor skips the HF function when that input is not fitted
  assign new_func = (w_data_ff[2:0] == FN_HF_FREQ && !hf_present) ? FN_PERIOD
                                                                   : w_data_ff[2:0];

  always_comb begin
    status             = 8'h00;
    status[STAT_BUSY]  = (state_ff != ST_IDLE);
    status[STAT_DONE]  = done_ff;
    status[STAT_UNDER] = under_ff;
    status[STAT_GATE]  = gate_ind;
    status[STAT_KILO]  = disp_kilo;
    status[STAT_MEGA]  = disp_mega;
    status[STAT_HF]    = hf_present;
    status[STAT_MRUN]  = man_run_ff;
  end

  // Address and data may arrive in either order; answer once both are in
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_got_ff    <= 1'b0;
      w_got_ff     <= 1'b0;
      aw_addr_ff   <= 8'h00;
      w_data_ff    <= 32'h0000_0000;
      w_strb_ff    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; start is a one-cycle pulse, lost while busy
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      func_ff     <= rtic_func_t'(CTRL_RESET[2:0]);
      start_ff    <= 1'b0;
      slope_a_ff  <= CTRL_RESET[CTRL_SLOPE_A];
      slope_b_ff  <= CTRL_RESET[CTRL_SLOPE_B];
      gate_sel_ff <= CTRL_RESET[CTRL_GATE_LSB +: 2];
    end else begin
      start_ff <= 1'b0;
      if (wr_fire && aw_addr_ff == OFS_CTRL && w_strb_ff[0]) begin
        func_ff     <= rtic_func_t'(new_func);
        start_ff    <= w_data_ff[CTRL_START];
        slope_a_ff  <= w_data_ff[CTRL_SLOPE_A];
        slope_b_ff  <= w_data_ff[CTRL_SLOPE_B];
        gate_sel_ff <= w_data_ff[CTRL_GATE_LSB +: 2];
      end
    end
  end

  // Read path: data registered, one word per request
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_CTRL:      s_axi_rdata <= {24'h000000, gate_sel_ff, slope_b_ff, slope_a_ff,
                                       1'b0, func_ff};
        OFS_STATUS:    s_axi_rdata <= {24'h000000, status};
        OFS_RESULT_LO: s_axi_rdata <= result_ff[31:0];
        OFS_RESULT_HI: s_axi_rdata <= result_ff[63:32];
        OFS_TOTAL_LO:  s_axi_rdata <= total[31:0];
        OFS_TOTAL_HI:  s_axi_rdata <= total[63:32];
        default:       s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: rtic_sva.sv
// Purpose: Port checks on rtic_core
// Assumes: One clock, reset active low
// Notes:   Bound into every rtic_core
module rtic_sva (
  // Bus and display
  input wire logic        clk_sys, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready, disp_kilo, disp_mega,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Response two edges after both halves are taken
  wr_ans_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("bvalid late");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready early");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  rd_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("rvalid late");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  r_end_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  prefix_one_a: assert property (disp_mega |-> !disp_kilo) else $error("two prefixes");
endmodule
bind rtic_core rtic_sva u_sva (.*);

// File: rtic_far.sv
// Purpose: Far side model: inputs A, B and the button
// Assumes: Driven just after rising edges
// Notes:   The bench calls its tasks
module rtic_far (
  // Clock and signals
  input wire logic clk_sys,
  output logic     in_a = 0, in_b = 0, btn_start_stop = 0
);
  timeunit 1ns; timeprecision 1ps;
  // A stays the faster input, one cycle high per pulse
  task automatic a_pulses(input int n, input int gap);
    repeat (n) begin
      @(posedge clk_sys) in_a <= 1;
      @(posedge clk_sys) in_a <= 0;
      repeat (gap - 1) @(posedge clk_sys);
    end
  endtask
  task automatic b_lvl(input logic v);
    @(posedge clk_sys) in_b <= v;
  endtask
  task automatic press(input int n);
    @(posedge clk_sys) btn_start_stop <= 1;
    repeat (n) @(posedge clk_sys);
    btn_start_stop <= 0;
  endtask
endmodule

// File: ratio_interval_totalize_counter_tb.sv
// Purpose: Self-checking bench for rtic_core
// Assumes: Gate and hold counts shortened
// Notes:   rtic_far drives A, B and the button
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin num_errors++; \
  $display("Error %s exp %0h got %0h", n, e, s); end end
module ratio_interval_totalize_counter_tb import rtic_pkg::*; ();
  timeunit 1ns; timeprecision 1ps;
  logic clk_sys = 0, rstn = 0, hf_present = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_a, in_b, btn_start_stop, gate_ind;
  logic disp_kilo, disp_mega;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, tc[4] = '{8'h0B, 8'h2B, 8'h0C, 8'h0B};
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, te[4] = '{5, 5, 8, 1000};
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int num_errors = 0, cmp_count = 0, tn[4] = '{5, 5, 5, 1000};
  rtic_core #(.GATE_A(200), .GATE_B(400), .GATE_C(800), .HOLD_LEN(50)) u_dut (.*);
  rtic_far u_far (.*);
  always #4 clk_sys = ~clk_sys;
  // Bus tasks: each valid drops at the edge it is taken; ready waits for the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, v, 2'h3};
    s_axi_bready <= 1'b1;
    fork
      @(posedge clk_sys iff s_axi_awready) s_axi_awvalid <= 1'b0;
      @(posedge clk_sys iff s_axi_wready) s_axi_wvalid <= 1'b0;
    join
    @(posedge clk_sys iff s_axi_bvalid) s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys) {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    @(posedge clk_sys iff s_axi_arready) s_axi_arvalid <= 1'b0;
    @(posedge clk_sys iff s_axi_rvalid) {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // Wait for done, then clear it so the next run starts clean
  task automatic fin();
    do rd(OFS_STATUS); while (d[STAT_DONE] !== 1'h1);
    wr(OFS_STATUS, 32'h2);
  endtask
  task automatic res();
    fin();
    rd(OFS_RESULT_LO);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1;
    rd(8'h18);
    `CHK("resp", RESP_SLVERR, r)
    wr(OFS_CTRL, 32'h6);
    rd(OFS_CTRL);
    `CHK("func", 32'h0, d)
    hf_present <= 1'b1;
    wr(OFS_CTRL, 32'h6);
    rd(OFS_CTRL);
    `CHK("hf func", 32'h6, d)
    {hf_present, s_axi_wstrb} <= 5'h00;
    wr(OFS_CTRL, 32'h5);
    rd(OFS_CTRL);
    `CHK("no strobe", 32'h6, d)
    s_axi_wstrb <= 4'hF;
    // Totalize rows: start edge, pulses, opposite edge, 3 pulses, start edge
    foreach (tc[i]) begin
      u_far.b_lvl(tc[i][5]);
      wr(OFS_CTRL, {24'h0, tc[i]});
      repeat (4) @(posedge clk_sys);
      u_far.b_lvl(!tc[i][5]);
      u_far.a_pulses(tn[i], 2);
      `CHK("gate on", 1'h1, gate_ind)
      u_far.b_lvl(tc[i][5]);
      u_far.a_pulses(3, 2);
      u_far.b_lvl(!tc[i][5]);
      fin();
      rd(OFS_TOTAL_LO);
      `CHK("total", te[i], d)
      `CHK("kilo", tn[i] > 999, disp_kilo)
      `CHK("mega", 1'h0, disp_mega)
    end
    // Period, ratio and interval; expected from the pulse spacing driven
    u_far.b_lvl(1'b0);
    wr(OFS_CTRL, 32'h8);
    u_far.a_pulses(2, 19);
    res();
    `CHK("period", 32'd20, d)
    wr(OFS_CTRL, 32'h48);
    u_far.a_pulses(32, 9);
    res();
    `CHK("avg period", 32'd10, d)
    wr(OFS_CTRL, 32'h49);
    fork
      u_far.a_pulses(40, 2);
      repeat (4) begin
        u_far.b_lvl(1'b1);
        u_far.b_lvl(1'b0);
      end
    join
    res();
    `CHK("ratio", 32'd10, d)
    wr(OFS_CTRL, 32'h1A);
    u_far.a_pulses(1, 30);
    u_far.b_lvl(1'b1);
    res();
    `CHK("interval", 32'd30, d)
    u_far.b_lvl(1'b0);
    wr(OFS_CTRL, 32'h4A);
    repeat (30) begin
      u_far.a_pulses(1, 5);
      u_far.b_lvl(1'b1);
      u_far.b_lvl(1'b0);
    end
    res();
    `CHK("avg interval", 32'd6, d)
    // Manual: press runs, press stops, long hold clears
    wr(OFS_CTRL, 32'h5);
    u_far.press(3);
    `CHK("gate", 1'h0, gate_ind)
    u_far.a_pulses(6, 2);
    u_far.press(3);
    u_far.a_pulses(2, 2);
    rd(OFS_TOTAL_LO);
    `CHK("manual", 32'h6, d)
    u_far.press(60);
    rd(OFS_TOTAL_LO);
    `CHK("cleared", 32'h0, d)
    // Reset in mid-run stops the manual count and clears status
    rstn <= 1'b0;
    @(posedge clk_sys) rstn <= 1'b1;
    rd(OFS_STATUS);
    `CHK("reset status", 32'h0, d)
    conclude();
  end
  task automatic conclude();
    $display("%0d checks, %0d errors", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog far beyond the few thousand cycles the tests need
  initial begin
    #200000 num_errors++;
    conclude();
  end
endmodule
